// File: hdl/mbhrr_pkg.sv
package mbhrr_pkg;
  // Map of holding registers
  localparam logic [15:0] REG_STATION_ADDR  = 16'h0020;
  localparam logic [15:0] REG_IDENT_CODE    = 16'h0021;
  localparam logic [15:0] REG_FMT_FIRST     = 16'h0200;
  localparam logic [15:0] REG_FMT_LAST      = 16'h0257;
  localparam logic [15:0] REG_INT_FIRST     = 16'h0400;
  localparam logic [15:0] REG_INT_LAST      = 16'h0457;
  localparam logic [15:0] REG_MFR_FIRST     = 16'hFFFB;
  localparam logic [15:0] REG_MFR_LAST      = 16'hFFFF;
  // Identification value is arbitrary
  localparam logic [15:0] IDENT_CODE_VALUE  = 16'h5A01;
  localparam logic [15:0] MAX_COUNT         = 16'h0020;
  localparam logic [7:0]  FUNCTION_CODE_FIELD_READ_HOLDING = 8'h03;
  localparam logic [7:0]  EXC_BAD_FUNCTION  = 8'h01;
  localparam logic [7:0]  EXC_BAD_ADDRESS   = 8'h02;
  localparam logic [7:0]  EXC_BAD_VALUE     = 8'h03;
  localparam logic [7:0]  EXC_FLAG          = 8'h80;
  localparam logic [15:0] CRC_INIT          = 16'hFFFF;
  localparam logic [15:0] CRC_POLY          = 16'hA001;
  localparam logic [15:0] STATUS_VALID      = 16'h0000;
  localparam logic [15:0] STATUS_NOT_READY  = 16'h0001;
  localparam logic [15:0] STATUS_DISABLED   = 16'hFFFF;
  localparam int          NUM_CHANNELS      = 22;
  localparam int          REQ_BYTES         = 8;
  localparam logic [3:0]  REQ_LAST_IDX      = 4'h7;
  localparam logic [7:0]  RSP_HEADER_BYTES  = 8'h03;
  localparam logic [15:0] MFR_INFO_VALUE    = 16'h0000;
endpackage : mbhrr_pkg

// File: hdl/mbhrr_crc16.sv
`timescale 1ns/100ps
module mbhrr_crc16 (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Control
  input  wire logic        crc_clear,
  input  wire logic        crc_step,
  input  wire logic [7:0]  crc_byte,
  // Result
  output logic      [15:0] crc_reg
);
  function automatic logic [15:0] mbhrr_crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ mbhrr_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : mbhrr_crc_byte

  always_ff @(posedge clk) begin
    if (srst || crc_clear) begin
      crc_reg <= mbhrr_pkg::CRC_INIT;
    end else if (crc_step) begin
      crc_reg <= mbhrr_crc_byte(crc_reg, crc_byte);
    end
  end
endmodule : mbhrr_crc16

// File: hdl/mbhrr_responder.sv
`timescale 1ns/100ps
module mbhrr_responder (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Configuration
  input  wire logic [7:0]  station_address,
  // Request byte stream
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        frame_end,
  // Channel data source
  output logic      [15:0] word_addr_reg,
  input  wire logic [15:0] word_data,
  // Response byte stream
  output logic             tx_valid_reg,
  output logic      [7:0]  tx_data_reg,
  input  wire logic        tx_ready,
  output logic             tx_last_reg,
  output logic             busy_reg
);
  typedef enum logic [3:0] {
    ST_RECV = 4'b0001,
    ST_CHECK = 4'b0010,
    ST_SEND = 4'b0100,
    ST_CRC  = 4'b1000
  } mbhrr_state_e;

  mbhrr_state_e state_reg;
  logic [7:0]   req_reg [mbhrr_pkg::REQ_BYTES];
  logic [3:0]   rx_cnt_reg;
  logic         overflow_reg;
  logic [7:0]   hdr_reg [3];
  logic [7:0]   hdr_len_reg;
  logic [7:0]   idx_reg;
  logic [7:0]   total_reg;
  logic         exc_reg;
  logic [15:0]  start_reg;
  logic         crc_clear;
  logic         crc_step;
  logic [7:0]   crc_byte;
  logic [15:0]  crc_reg;
  logic [7:0]   byte_now;
  logic [15:0]  reg_word;
  logic [15:0]  rd_addr;
  logic         crc_phase_reg;

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_range

  function automatic logic block_ok(input logic [15:0] s, input logic [15:0] e);
    return (in_range(s, mbhrr_pkg::REG_STATION_ADDR, mbhrr_pkg::REG_IDENT_CODE)
            && in_range(e, mbhrr_pkg::REG_STATION_ADDR, mbhrr_pkg::REG_IDENT_CODE))
        || (in_range(s, mbhrr_pkg::REG_FMT_FIRST, mbhrr_pkg::REG_FMT_LAST)
            && in_range(e, mbhrr_pkg::REG_FMT_FIRST, mbhrr_pkg::REG_FMT_LAST))
        || (in_range(s, mbhrr_pkg::REG_INT_FIRST, mbhrr_pkg::REG_INT_LAST)
            && in_range(e, mbhrr_pkg::REG_INT_FIRST, mbhrr_pkg::REG_INT_LAST))
        || (in_range(s, mbhrr_pkg::REG_MFR_FIRST, mbhrr_pkg::REG_MFR_LAST)
            && (e >= s));
  endfunction : block_ok

  mbhrr_crc16 u_crc (
    .clk       (clk),
    .srst      (srst),
    .crc_clear (crc_clear),
    .crc_step  (crc_step),
    .crc_byte  (crc_byte),
    .crc_reg   (crc_reg)
  );

  // Data byte index within payload
  logic [7:0] data_idx;
  assign data_idx = idx_reg - hdr_len_reg;
  assign rd_addr  = start_reg + {9'h000, data_idx[7:1]};

  // Register content: own fields or the external channel source
  always_comb begin
    if (rd_addr == mbhrr_pkg::REG_STATION_ADDR) begin
      reg_word = {8'h00, station_address};
    end else if (rd_addr == mbhrr_pkg::REG_IDENT_CODE) begin
      reg_word = mbhrr_pkg::IDENT_CODE_VALUE;
    end else if (rd_addr >= mbhrr_pkg::REG_MFR_FIRST) begin
      reg_word = mbhrr_pkg::MFR_INFO_VALUE;
    end else begin
      reg_word = word_data;
    end
  end

  always_comb begin
    if (idx_reg < hdr_len_reg) begin
      byte_now = hdr_reg[idx_reg[1:0]];
    end else begin
      byte_now = data_idx[0] ? reg_word[7:0] : reg_word[15:8];
    end
  end

  // Clear after the final byte so the next request starts from the initial value
  assign crc_clear = (state_reg == ST_CHECK) || (state_reg == ST_RECV && frame_end)
                   || (state_reg == ST_CRC && crc_phase_reg && tx_valid_reg && tx_ready);
  assign crc_step  = (state_reg == ST_RECV && rx_valid && !frame_end)
                   || (state_reg == ST_SEND && tx_ready && tx_valid_reg);
  assign crc_byte  = (state_reg == ST_RECV) ? rx_data : tx_data_reg;

  // Request capture
  always_ff @(posedge clk) begin
    if (srst || state_reg != ST_RECV || frame_end) begin
      rx_cnt_reg   <= 4'h0;
      overflow_reg <= 1'b0;
    end else if (rx_valid) begin
      if (rx_cnt_reg < 4'(mbhrr_pkg::REQ_BYTES)) begin
        req_reg[rx_cnt_reg[2:0]] <= rx_data;
        rx_cnt_reg <= rx_cnt_reg + 4'h1;
      end else begin
        overflow_reg <= 1'b1;
      end
    end
  end

  // Frame decoding and response sequencing
  always_ff @(posedge clk) begin
    logic [15:0] cnt;
    logic [15:0] last;
    cnt  = {req_reg[4], req_reg[5]};
    last = {req_reg[2], req_reg[3]} + cnt - 16'h0001;
    if (srst) begin
      state_reg     <= ST_RECV;
      tx_valid_reg  <= 1'b0;
      tx_data_reg   <= 8'h00;
      tx_last_reg   <= 1'b0;
      busy_reg      <= 1'b0;
      idx_reg       <= 8'h00;
      total_reg     <= 8'h00;
      hdr_len_reg   <= 8'h00;
      exc_reg       <= 1'b0;
      start_reg     <= 16'h0000;
      crc_phase_reg <= 1'b0;
      word_addr_reg <= 16'h0000;
      for (int i = 0; i < 3; i++) begin
        hdr_reg[i] <= 8'h00;
      end
    end else begin
      case (state_reg)
        ST_RECV: begin
          // Frame end after exactly 8 bytes; residue zero means checksum ok
          if (frame_end && rx_cnt_reg == 4'(mbhrr_pkg::REQ_BYTES) && !overflow_reg
              && crc_reg == 16'h0000 && req_reg[0] == station_address) begin
            state_reg <= ST_CHECK;
            busy_reg  <= 1'b1;
          end
        end
        ST_CHECK: begin
          hdr_reg[0] <= station_address;
          start_reg  <= {req_reg[2], req_reg[3]};
          idx_reg    <= 8'h00;
          exc_reg    <= 1'b1;
          hdr_len_reg <= mbhrr_pkg::RSP_HEADER_BYTES;
          hdr_reg[1] <= req_reg[1] | mbhrr_pkg::EXC_FLAG;
          total_reg  <= mbhrr_pkg::RSP_HEADER_BYTES;
          if (req_reg[1] != mbhrr_pkg::FUNCTION_CODE_FIELD_READ_HOLDING) begin
            hdr_reg[2] <= mbhrr_pkg::EXC_BAD_FUNCTION;
          end else if (cnt == 16'h0000 || cnt > mbhrr_pkg::MAX_COUNT) begin
            hdr_reg[2] <= mbhrr_pkg::EXC_BAD_VALUE;
          end else if (!block_ok({req_reg[2], req_reg[3]}, last)) begin
            hdr_reg[2] <= mbhrr_pkg::EXC_BAD_ADDRESS;
          end else begin
            exc_reg    <= 1'b0;
            hdr_reg[1] <= req_reg[1];
            hdr_reg[2] <= {cnt[6:0], 1'b0};
            total_reg  <= mbhrr_pkg::RSP_HEADER_BYTES + {cnt[6:0], 1'b0};
          end
          state_reg <= ST_SEND;
        end
        ST_SEND: begin
          word_addr_reg <= rd_addr;
          // Data bytes wait until the source answers the current address
          if (!tx_valid_reg && (idx_reg < hdr_len_reg || word_addr_reg == rd_addr)) begin
            tx_valid_reg <= 1'b1;
            tx_data_reg  <= byte_now;
          end else if (tx_valid_reg && tx_ready) begin
            if (idx_reg + 8'h01 == total_reg) begin
              tx_valid_reg <= 1'b0;
              state_reg    <= ST_CRC;
              crc_phase_reg <= 1'b0;
            end else begin
              tx_valid_reg <= 1'b0;
              idx_reg      <= idx_reg + 8'h01;
            end
          end
        end
        ST_CRC: begin
          if (!tx_valid_reg) begin
            tx_valid_reg <= 1'b1;
            tx_data_reg  <= crc_phase_reg ? crc_reg[15:8] : crc_reg[7:0];
            tx_last_reg  <= crc_phase_reg;
          end else if (tx_ready) begin
            tx_valid_reg <= 1'b0;
            tx_last_reg  <= 1'b0;
            if (crc_phase_reg) begin
              state_reg <= ST_RECV;
              busy_reg  <= 1'b0;
            end
            crc_phase_reg <= 1'b1;
          end
        end
        default: begin
          state_reg <= ST_RECV;
        end
      endcase
    end
  end
endmodule : mbhrr_responder

// File: testbench/mbhrr_master.sv
`timescale 1ns/100ps
module mbhrr_master (
  // Clock
  input  wire logic       clk,
  // Request stream
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            frame_end,
  // Response stream
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready
);
  logic [7:0] got[$];
  int         last_at;
  initial begin
    rx_valid  = 1'b0;
    rx_data   = 8'h00;
    frame_end = 1'b0;
    tx_ready  = 1'b0;
  end
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction : crc16
  task automatic send(input logic [47:0] h, input bit bad);
    logic [7:0]  q[$];
    logic [15:0] c;
    for (int i = 5; i >= 0; i--) q.push_back(h[i*8+:8]);
    c = crc16(q) ^ {15'h0000, bad};
    q = {q, c[7:0], c[15:8]};
    @(posedge clk);
    #1;
    foreach (q[i]) begin
      rx_valid = 1'b1;
      rx_data  = q[i];
      @(posedge clk);
      #1;
    end
    rx_valid  = 1'b0;
    rx_data   = ~rx_data;
    frame_end = 1'b1;
    @(posedge clk);
    #1;
    frame_end = 1'b0;
  endtask : send
  // Random stalls on the response side
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
      if (tx_last) last_at = got.size();
    end
    #1 tx_ready = ($urandom % 4) != 0;
  end
endmodule : mbhrr_master

// File: testbench/mbhrr_responder_assertions.sv
`timescale 1ns/100ps
module mbhrr_responder_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       srst,
  // Observed ports
  input wire logic [7:0] station_address,
  input wire logic       frame_end,
  input wire logic       tx_valid_reg,
  input wire logic [7:0] tx_data_reg,
  input wire logic       tx_ready,
  input wire logic       tx_last_reg,
  input wire logic       busy_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_last_taken;
    tx_valid_reg && tx_ready && tx_last_reg;
  endsequence
  sequence s_idle_after;
    !busy_reg ##1 !tx_valid_reg;
  endsequence
  a_valid_holds: assert property (
    tx_valid_reg && !tx_ready |=> tx_valid_reg && $stable(tx_data_reg))
    else $error("response byte dropped before accept");
  a_gap_after: assert property (
    tx_valid_reg && tx_ready |=> !tx_valid_reg)
    else $error("no gap after accepted byte");
  a_last_valid: assert property (
    tx_last_reg |-> tx_valid_reg)
    else $error("last flag without valid byte");
  a_first_byte: assert property (
    $rose(busy_reg) |-> ##2 tx_valid_reg && tx_data_reg == station_address)
    else $error("first byte not station address");
  a_busy_end: assert property (
    s_last_taken |=> s_idle_after)
    else $error("busy after final byte");
  a_no_tx_idle: assert property (
    !busy_reg |-> !tx_valid_reg)
    else $error("output while not busy");
  a_busy_bounded: assert property (
    $rose(busy_reg) |-> ##[1:1000] !busy_reg)
    else $error("response too long");
  a_resp_start: assert property (
    $rose(busy_reg) |-> $past(frame_end))
    else $error("busy without frame end");
endmodule : mbhrr_responder_chk
bind mbhrr_responder mbhrr_responder_chk chk_i (.clk(clk), .srst(srst),
  .station_address(station_address), .frame_end(frame_end), .tx_valid_reg(tx_valid_reg),
  .tx_data_reg(tx_data_reg), .tx_ready(tx_ready), .tx_last_reg(tx_last_reg),
  .busy_reg(busy_reg));

// File: testbench/mbhrr_responder_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] %0t %h %h", $time, (a), (b)); end end
module mbhrr_responder_tb;
  logic clk, srst, rx_valid, frame_end, tx_valid_reg, tx_ready, tx_last_reg, busy_reg;
  logic [7:0]  station_address, rx_data, tx_data_reg;
  logic [15:0] word_addr_reg, word_data, word_key;
  int          mismatches, check_count;
  mbhrr_responder mbhrr_responder_i (.clk(clk), .srst(srst), .station_address(station_address),
    .rx_valid(rx_valid), .rx_data(rx_data), .frame_end(frame_end), .word_addr_reg(word_addr_reg),
    .word_data(word_data), .tx_valid_reg(tx_valid_reg), .tx_data_reg(tx_data_reg),
    .tx_ready(tx_ready), .tx_last_reg(tx_last_reg), .busy_reg(busy_reg));
  mbhrr_master mbhrr_master_i (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .frame_end(frame_end), .tx_valid(tx_valid_reg), .tx_data(tx_data_reg),
    .tx_last(tx_last_reg), .tx_ready(tx_ready));
  // Channel source answers the fetched address
  assign word_data = word_addr_reg ^ word_key;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic print_verdict;
    if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  function automatic logic [15:0] word(input int a);
    if (a == 32'h20) return {8'h00, station_address};
    if (a == 32'h21) return mbhrr_pkg::IDENT_CODE_VALUE;
    if (a >= 32'hFFFB) return 16'h0000;
    return 16'(a) ^ word_key;
  endfunction : word
  task automatic run(input logic [7:0] sa, input logic [7:0] fc, input logic [15:0] st,
                     input logic [15:0] ct, input bit bad);
    logic [7:0]  e[$];
    logic [15:0] c;
    int          s, l, n;
    s = st;
    l = s + ct - 1;
    word_key = 16'($urandom);
    mbhrr_master_i.got.delete();
    mbhrr_master_i.last_at = 0;
    mbhrr_master_i.send({sa, fc, st, ct}, bad);
    repeat (3) @(posedge clk);
    n = 0;
    while (busy_reg !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) mismatches++;
    if (sa == station_address && !bad) begin
      e = {sa};
      if (fc != 8'h03) e = {e, fc | 8'h80, 8'h01};
      else if (ct == 0 || ct > 32) e = {e, 8'h83, 8'h03};
      else if (!((s >= 'h20 && l <= 'h21) || (s >= 'h200 && l <= 'h257) ||
                 (s >= 'h400 && l <= 'h457) || (s >= 'hFFFB && l <= 'hFFFF)))
        e = {e, 8'h83, 8'h02};
      else begin
        e = {e, fc, 8'(ct * 2)};
        for (int i = s; i <= l; i++) e = {e, 8'(word(i) >> 8), 8'(word(i))};
      end
      c = mbhrr_master_i.crc16(e);
      e = {e, c[7:0], c[15:8]};
    end
    `CHK(mbhrr_master_i.got.size(), e.size())
    `CHK(mbhrr_master_i.last_at, e.size())
    foreach (e[i]) `CHK(mbhrr_master_i.got[i], e[i])
  endtask : run
  initial begin
    #1000000;
    mismatches++;
    print_verdict();
  end
  initial begin
    srst = 1'b1;
    word_key = 16'h0000;
    void'($urandom(32'hF586));
    station_address = 8'(1 + $urandom % 200);
    repeat (5) @(posedge clk);
    #1 srst = 1'b0;
    run(station_address, 8'h03, 16'h0021, 16'h0001, 0);
    run(station_address, 8'h03, 16'h0020, 16'h0002, 0);
    run(station_address, 8'h03, 16'h0400, 16'h0003, 0);
    run(station_address, 8'h03, 16'h0200, 16'h0020, 0);
    run(station_address, 8'h03, 16'h0200, 16'h0021, 0);
    run(station_address, 8'h03, 16'h0400, 16'h0000, 0);
    run(station_address, 8'h06, 16'h0021, 16'h0001, 0);
    run(station_address, 8'h03, 16'h0300, 16'h0001, 0);
    run(station_address, 8'h03, 16'h0456, 16'h0003, 0);
    run(station_address, 8'h03, 16'hFFFB, 16'h0005, 0);
    run(station_address + 8'h01, 8'h03, 16'h0021, 16'h0001, 0);
    run(station_address, 8'h03, 16'h0021, 16'h0001, 1);
    repeat (4) run(station_address, 8'h03, 16'(16'h0200 + $urandom % 80),
                   16'(1 + $urandom % 8), 0);
    print_verdict();
  end
endmodule : mbhrr_responder_tb
